// ---- io_sel_map.vh ----
// Register offsets, field positions, reset values and pin routing for the input select block
// Operation
// R1 - Timer P clock source bits 6..3 pick pins
// R2 - Timer S clock source bits 2..0 pick pins
// R3 - Bit 7 of selects 0/1 reads zero
// R4 - Bits 6..4 route serial select/data/clock
// R5 - Bits 3..0 route external irq 3..0
// R6 - UART receive select bits 1..0, rest zero
// R7 - Mode flag only on unlock code 11001010
// R8 - Mode off: pins act as selected function
// R9 - Mode on: port read returns pin levels
// R10 - Mode off: output function reads 0/latch
// R11 - Mode off: analog path only if selected
// R12 - Mode on: chosen converter channel path on
// R13 - Port data and direction reset to ones
// R14 - Direction by word write or bit op
// R15 - Bit op reads port, modifies, writes back
// R16 - Port A falling edge wakes from sleep
// R17 - Select and unlock registers reset to zero
`ifndef IO_SEL_MAP_VH
`define IO_SEL_MAP_VH

// Register byte offsets
`define IO_TSEL_OFS 8'h00
`define IO_SSEL_OFS 8'h04
`define IO_USEL_OFS 8'h08
`define IO_UNLK_OFS 8'h0c
`define IO_STAT_OFS 8'h10
`define IO_WAKE_OFS 8'h14
`define IO_BITOP_OFS 8'h18
`define IO_PORT_BASE 8'h20

// Implemented bit masks
`define IO_TSEL_MASK 8'h7f
`define IO_SSEL_MASK 8'h7f
`define IO_USEL_MASK 8'h03

// Reset values
`define IO_SEL_RST 8'h00
`define IO_UNLK_RST 8'h00
`define IO_WAKE_RST 8'h00
`define IO_PORT_RST 8'hff

// Unlock code for read-port mode
`define IO_UNLK_CODE 8'hca

// Bit-op register fields
`define IO_BOP_BIT 2:0
`define IO_BOP_PORT 5:3
`define IO_BOP_DIR 6
`define IO_BOP_VAL 7

// Status fields
`define IO_STAT_MODE 0

// Routed inputs, six-bit pin index each (port*8+bit), order:
// st0 st1 st2 pt0 pt1 pt2 pt3 irq0 irq1 irq2 irq3 sck sdi scs rx0 rx1
`define IO_ROUTE_N 16
`define IO_ROUTE_PRI {6'd25, 6'd6, 6'd1, 6'd4, 6'd5, 6'd5, 6'd4, 6'd3, 6'd1, \
  6'd29, 6'd27, 6'd21, 6'd19, 6'd46, 6'd25, 6'd23}
`define IO_ROUTE_ALT {6'd46, 6'd28, 6'd40, 6'd42, 6'd43, 6'd23, 6'd24, 6'd7, 6'd6, \
  6'd9, 6'd10, 6'd34, 6'd44, 6'd8, 6'd15, 6'd32}

`endif

// ---- io_sel_pins.sv ----
// External pin model for the input select block
module io_sel_pins #(
  parameter W = 48
) (
  input wire [W-1:0] ext,
  input wire [W-1:0] pin_out,
  input wire [W-1:0] pin_oe,
  output wire [W-1:0] pin_in
);
  // Driven pins show the block's level, others the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// ---- io_sel_props.sv ----
// Port assertions for the input select block
module io_sel_props #(
  parameter NPORT = 6
) (
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [15:0] an_func_sel,
  input wire [3:0] adc_chan,
  input wire sleep_mode,
  input wire [15:0] an_path_en,
  input wire read_port_mode_flag,
  input wire wake_req
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire done = psel && penable && pready;
  wire unlk_wr = done && pwrite && paddr == 8'h0c;
  ////////////////////////////////////////
  sequence s_start;
    psel && penable && $rose(penable);
  endsequence
  sequence s_long;
    !pready ##1 pready;
  endsequence
  property p_ans;
    s_start ##0 paddr != 8'h18 |=> pready;
  endproperty
  property p_bop;
    s_start ##0 (pwrite && paddr == 8'h18) |=> s_long;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_unmap;
    done && (paddr == 8'h1c || paddr >= 8'h20 + NPORT * 8) |-> pslverr && prdata == 32'h0;
  endproperty
  property p_rsv;
    done && !pwrite && paddr <= 8'h04 |-> prdata[31:7] == 25'h0;
  endproperty
  property p_mode_on;
    unlk_wr && pwdata[7:0] == 8'hca |=> ##1 read_port_mode_flag;
  endproperty
  property p_mode_off;
    unlk_wr && pwdata[7:0] != 8'hca |=> ##1 !read_port_mode_flag;
  endproperty
  property p_path_on;
    read_port_mode_flag |=> an_path_en[$past(adc_chan)];
  endproperty
  property p_path_off;
    !read_port_mode_flag |=> (an_path_en & ~$past(an_func_sel)) == 16'h0;
  endproperty
  property p_wake;
    wake_req |-> $past(sleep_mode);
  endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  a_bop: assert property (p_bop) else $error("bit op answer timing");
  a_err: assert property (p_err) else $error("error without ready");
  a_unmap: assert property (p_unmap) else $error("unmapped access"); 
  a_rsv: assert property (p_rsv) else $error("bit 7 not zero");
  a_mode_on: assert property (p_mode_on) else $error("mode not set");
  a_mode_off: assert property (p_mode_off) else $error("mode not clear");
  a_path_on: assert property (p_path_on) else $error("path not forced");
  a_path_off: assert property (p_path_off) else $error("stray path");
  a_wake: assert property (p_wake) else $error("wake while awake");
endmodule

// ---- io_sel_sync.v ----
// Two-flop synchroniser for a vector of pin levels
module io_sel_sync #(
  parameter W = 8
) (
  input wire core_clk,
  input wire rst,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // Reset pins read high, matching the pull-high input state
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule

// ---- io_sel_top.v ----
// Input pin routing, read-port self-test, port registers and Port A wake-up
//
// Register access over APB and the placing of the registers were left to the implementer.
`include "io_sel_map.vh"

module io_sel_top #(
  parameter NPORT = 6
) (
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [NPORT*8-1:0] pin_in,
  output wire [NPORT*8-1:0] pin_out,
  output wire [NPORT*8-1:0] pin_oe,
  input wire [NPORT*8-1:0] pin_analog,
  input wire [NPORT*8-1:0] pin_periph_out,
  input wire [NPORT*8-1:0] pin_serial_out,
  input wire [15:0] an_func_sel,
  input wire [3:0] adc_chan,
  input wire sleep_mode,
  output wire [15:0] an_path_en,
  output wire [3:0] ptimer_clock_input,
  output wire [2:0] stimer_clock_input,
  output wire [3:0] ext_irq_in,
  output wire serial_select_in,
  output wire serial_data_in,
  output wire serial_clock_in,
  output wire [1:0] uart_rx_in,
  output wire read_port_mode_flag,
  output wire wake_req
);

  localparam W = NPORT * 8;

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_FETCH = 3'b010;
  localparam [2:0] S_HOLD = 3'b100;

  ////////////////////////////////////////////////////////////////////////
  // State

  reg [7:0] tsel_q;
  reg [7:0] ssel_q;
  reg [7:0] usel_q;
  reg [7:0] unlk_q;
  reg [7:0] wake_en_q;
  reg [W-1:0] latch_q;
  reg [W-1:0] dir_q;
  reg [2:0] state_q;
  reg [7:0] tmp_q;
  reg [7:0] bop_q;
  reg pready_q;
  reg pslverr_q;
  reg [31:0] prdata_q;
  reg mode_q;
  reg [15:0] an_en_q;
  reg [`IO_ROUTE_N-1:0] route_q;
  reg [7:0] pa_prev_q;
  reg wake_q;

  wire [W-1:0] pin_lvl;
  wire [W-1:0] port_rd;
  wire [`IO_ROUTE_N-1:0] route_sel;
  wire [`IO_ROUTE_N-1:0] route_d;
  wire [6*`IO_ROUTE_N-1:0] route_pri;
  wire [6*`IO_ROUTE_N-1:0] route_alt;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  io_sel_sync #(
    .W(W)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d(pin_in),
    .q(pin_lvl)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read-port mode flag, decoded from the unlock register

  wire mode_d = (unlk_q == `IO_UNLK_CODE); // R7

  ////////////////////////////////////////////////////////////////////////
  // Per-pin read value

  genvar gi;
  generate
    for (gi = 0; gi < W; gi = gi + 1) begin : g_rd
      reg rd;
      always @* begin
        if (mode_q) begin
          rd = pin_lvl[gi]; // R9
        end else if (pin_analog[gi]) begin
          rd = 1'b0; // R8
        end else if (pin_periph_out[gi]) begin
          rd = dir_q[gi] ? 1'b0 : latch_q[gi]; // R10
        end else if (pin_serial_out[gi]) begin
          rd = dir_q[gi] ? pin_lvl[gi] : latch_q[gi]; // R8
        end else begin
          rd = pin_lvl[gi]; // R8
        end
      end
      assign port_rd[gi] = rd;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Input source routing

  assign route_sel = {usel_q[1:0], ssel_q[6:0], tsel_q[6:0]};
  assign route_pri = `IO_ROUTE_PRI;
  assign route_alt = `IO_ROUTE_ALT;

  generate
    for (gi = 0; gi < `IO_ROUTE_N; gi = gi + 1) begin : g_route
      // R1 R2 R4 R5 R6
      assign route_d[gi] = route_sel[gi] ? pin_lvl[route_alt[gi*6+:6]] : pin_lvl[route_pri[gi*6+:6]];
    end
  endgenerate

  assign stimer_clock_input = route_q[2:0];
  assign ptimer_clock_input = route_q[6:3];
  assign ext_irq_in = route_q[10:7];
  assign serial_clock_in = route_q[11];
  assign serial_data_in = route_q[12];
  assign serial_select_in = route_q[13];
  assign uart_rx_in = route_q[15:14];

  ////////////////////////////////////////////////////////////////////////
  // Analog path enables

  reg [15:0] an_en_d;
  always @* begin
    an_en_d = an_func_sel; // R11
    if (mode_q) begin
      an_en_d[adc_chan] = 1'b1; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  wire access = psel & penable;
  wire port_hit = (paddr >= `IO_PORT_BASE);
  wire [7:0] port_off = paddr - `IO_PORT_BASE;
  wire [4:0] port_idx = port_off[7:3];
  wire port_dir = port_off[2];
  wire port_ok = port_hit & (port_idx < NPORT) & (paddr[1:0] == 2'b00);
  wire [2:0] pidx = port_idx[2:0];

  reg [7:0] rdata;
  reg hit;
  always @* begin
    rdata = 8'h00;
    hit = 1'b1;
    case (paddr)
      `IO_TSEL_OFS: rdata = tsel_q; // R3
      `IO_SSEL_OFS: rdata = ssel_q; // R3
      `IO_USEL_OFS: rdata = usel_q; // R6
      `IO_UNLK_OFS: rdata = unlk_q;
      `IO_STAT_OFS: rdata = {7'h00, mode_q};
      `IO_WAKE_OFS: rdata = wake_en_q;
      `IO_BITOP_OFS: rdata = bop_q;
      default: begin
        if (port_ok) begin
          rdata = port_dir ? dir_q[pidx*8+:8] : port_rd[pidx*8+:8];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit operation source and modify

  wire [7:0] bop_w = pwdata[7:0];
  wire [2:0] bop_port = bop_w[`IO_BOP_PORT];
  wire [2:0] bop_bit = bop_w[`IO_BOP_BIT];
  wire bop_ok = (bop_port < NPORT);
  // Data target reads the whole port as software would, so inputs may be rewritten
  wire [7:0] bop_src = bop_w[`IO_BOP_DIR] ? dir_q[bop_port*8+:8] : port_rd[bop_port*8+:8]; // R15

  reg [7:0] bop_mod;
  always @* begin
    bop_mod = bop_src;
    bop_mod[bop_bit] = bop_w[`IO_BOP_VAL]; // R15
  end

  wire bop_start = access & ~pready_q & pwrite & (paddr == `IO_BITOP_OFS) & (state_q == S_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // APB handshake; writes commit on the completing edge

  wire done = access & pready_q;
  wire wr = done & pwrite & ~pslverr_q;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      tmp_q <= 8'h00;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (bop_start) begin
            state_q <= S_FETCH;
          end else if (access & ~pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= ~hit;
            prdata_q <= {24'h000000, rdata};
          end
        end
        S_FETCH: begin
          // Read then modify; the write back happens on the completing edge
          tmp_q <= bop_mod; // R15
          pready_q <= 1'b1;
          pslverr_q <= ~bop_ok;
          prdata_q <= 32'h00000000;
          state_q <= S_HOLD;
        end
        S_HOLD: begin
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tsel_q <= `IO_SEL_RST; // R17
      ssel_q <= `IO_SEL_RST; // R17
      usel_q <= `IO_SEL_RST; // R17
      unlk_q <= `IO_UNLK_RST; // R17
      wake_en_q <= `IO_WAKE_RST;
      bop_q <= 8'h00;
    end else if (wr) begin
      case (paddr)
        `IO_TSEL_OFS: tsel_q <= pwdata[7:0] & `IO_TSEL_MASK; // R3
        `IO_SSEL_OFS: ssel_q <= pwdata[7:0] & `IO_SSEL_MASK; // R3
        `IO_USEL_OFS: usel_q <= pwdata[7:0] & `IO_USEL_MASK; // R6
        `IO_UNLK_OFS: unlk_q <= pwdata[7:0];
        `IO_WAKE_OFS: wake_en_q <= pwdata[7:0];
        `IO_BITOP_OFS: bop_q <= pwdata[7:0];
        default: begin
          bop_q <= bop_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port data latches and direction registers

  generate
    for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_port
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          latch_q[gi*8+:8] <= `IO_PORT_RST; // R13
          dir_q[gi*8+:8] <= `IO_PORT_RST; // R13
        end else if (wr & (state_q == S_HOLD)) begin
          if (bop_port == gi) begin
            if (bop_w[`IO_BOP_DIR]) begin
              dir_q[gi*8+:8] <= tmp_q; // R14
            end else begin
              latch_q[gi*8+:8] <= tmp_q; // R15
            end
          end
        end else if (wr & port_ok & (pidx == gi)) begin
          if (port_dir) begin
            dir_q[gi*8+:8] <= pwdata[7:0]; // R14
          end else begin
            latch_q[gi*8+:8] <= pwdata[7:0];
          end
        end
      end
    end
  endgenerate

  // Direction bit 1 means input, so the driver is enabled on 0
  reg [W-1:0] pin_out_q;
  reg [W-1:0] pin_oe_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_out_q <= {W{1'b1}};
      pin_oe_q <= {W{1'b0}};
    end else begin
      pin_out_q <= latch_q;
      pin_oe_q <= ~dir_q;
    end
  end

  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Mode, routing and analog outputs

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q <= 1'b0;
      route_q <= {`IO_ROUTE_N{1'b1}};
      an_en_q <= 16'h0000;
    end else begin
      mode_q <= mode_d; // R7
      route_q <= route_d; // R8
      an_en_q <= an_en_d;
    end
  end

  assign read_port_mode_flag = mode_q;
  assign an_path_en = an_en_q;

  ////////////////////////////////////////////////////////////////////////
  // Port A wake-up on a falling edge

  // Edge seen on synchronised levels only, so a short glitch may be missed
  wire [7:0] pa_fall = pa_prev_q & ~pin_lvl[7:0] & wake_en_q;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pa_prev_q <= 8'hff;
      wake_q <= 1'b0;
    end else begin
      pa_prev_q <= pin_lvl[7:0];
      wake_q <= sleep_mode & (|pa_fall); // R16
    end
  end

  assign wake_req = wake_q;

endmodule

// ---- tb_top.sv ----
// Testbench for the input select block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam NPORT = 6;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sleep_mode = 0;
  logic [7:0] paddr = 8'h0, rd_q;
  logic [31:0] pwdata = 32'h0;
  logic [47:0] ext = {48{1'b1}}, pin_analog = 48'h0, pin_periph_out = 48'h0, pin_serial_out = 48'h0;
  logic [15:0] an_func_sel = 16'h0001, ex;
  logic [3:0] adc_chan = 4'h5;
  logic err_q;
  wire [31:0] prdata;
  wire pready, pslverr, read_port_mode_flag, wake_req, serial_select_in, serial_data_in, serial_clock_in;
  wire [47:0] pin_in, pin_out, pin_oe;
  wire [15:0] an_path_en;
  wire [3:0] ptimer_clock_input, ext_irq_in;
  wire [2:0] stimer_clock_input;
  wire [1:0] uart_rx_in;
  int errors = 0, n_compared = 0, seen;
  int pri [16] = '{23, 25, 46, 19, 21, 27, 29, 1, 3, 4, 5, 5, 4, 1, 6, 25};
  int alt [16] = '{32, 15, 8, 44, 34, 10, 9, 6, 7, 24, 23, 43, 42, 40, 28, 46};
  wire [15:0] routed = {uart_rx_in, serial_select_in, serial_data_in, serial_clock_in, ext_irq_in,
    ptimer_clock_input, stimer_clock_input};
  io_sel_top #(.NPORT(NPORT)) DUT (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_analog, .pin_periph_out, .pin_serial_out,
    .an_func_sel, .adc_chan, .sleep_mode, .an_path_en, .ptimer_clock_input, .stimer_clock_input,
    .ext_irq_in, .serial_select_in, .serial_data_in, .serial_clock_in, .uart_rx_in,
    .read_port_mode_flag, .wake_req);
  io_sel_pins u_pins (.ext, .pin_out, .pin_oe, .pin_in);
  ////////////////////////////////////////
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task chk(input [47:0] got, input [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Request held until pready is sampled high
  task xfer(input [7:0] a, input w, input [7:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    rd_q = prdata[7:0];
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task settle;
    repeat (5) @(posedge core_clk);
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    chk(pin_oe, 48'h0);
    chk(pin_out, {48{1'b1}});
    for (int a = 0; a < 16; a += 4) begin
      xfer(8'(a), 0, 8'h0);
      chk(rd_q, 8'h0);
    end
    for (int p = 0; p < NPORT; p++) begin
      xfer(8'(8'h24 + 8 * p), 0, 8'h0);
      chk(rd_q, 8'hff);
    end
    xfer(8'h1c, 1, 8'h55);
    xfer(8'h1c, 0, 8'h0);
    chk({err_q, rd_q}, 9'h100);
    $display("test reset done");
    for (int s = 0; s < 2; s++) begin
      for (int r = 0; r < 3; r++) begin
        xfer(8'(r * 4), 1, s ? 8'hff : 8'h0);
        xfer(8'(r * 4), 0, 8'h0);
        chk(rd_q, s ? (r == 2 ? 8'h03 : 8'h7f) : 8'h0);
      end
      for (int k = 0; k < 16; k++) begin
        ext <= ~(48'h1 << (s ? alt[k] : pri[k]));
        settle;
        for (int j = 0; j < 16; j++) ex[j] = ext[s ? alt[j] : pri[j]];
        chk(routed, ex);
      end
    end
    $display("test routing done");
    ext <= {40'hff_ffff_ffff, 8'h5a};
    pin_analog <= 48'h0f;
    settle;
    xfer(8'h20, 0, 8'h0);
    chk(rd_q, 8'h50);
    chk(an_path_en, 16'h0001);
    xfer(8'h0c, 1, 8'hca);
    settle;
    chk(read_port_mode_flag, 1'b1);
    chk(an_path_en[5], 1'b1);
    xfer(8'h10, 0, 8'h0);
    chk(rd_q, 8'h01);
    xfer(8'h20, 0, 8'h0);
    chk(rd_q, 8'h5a);
    xfer(8'h0c, 1, 8'hcb);
    settle;
    chk(read_port_mode_flag, 1'b0);
    chk(an_path_en, 16'h0001);
    xfer(8'h20, 0, 8'h0);
    chk(rd_q, 8'h50);
    $display("test read port done");
    pin_analog <= 48'h0;
    ext <= 48'h0;
    xfer(8'h24, 1, 8'h0f);
    xfer(8'h18, 1, 8'h40);
    xfer(8'h24, 0, 8'h0);
    chk(rd_q, 8'h0e);
    settle;
    chk(pin_oe[7:0], 8'hf1);
    // Plain latch clear would give fe
    xfer(8'h18, 1, 8'h00);
    settle;
    chk(pin_out[7:0], 8'hf0);
    xfer(8'h20, 0, 8'h0);
    chk(rd_q, 8'hf0);
    $display("test bit op done");
    // Inputs high so peripheral-output reads differ from pin levels; serial-output reads still match them
    ext <= {48{1'b1}};
    pin_periph_out <= 48'hff;
    settle;
    xfer(8'h20, 0, 8'h0);
    chk(rd_q, 8'hf0);
    pin_periph_out <= 48'h0;
    pin_serial_out <= 48'hff;
    xfer(8'h20, 0, 8'h0);
    chk(rd_q, 8'hfe);
    pin_serial_out <= 48'h0;
    ext <= 48'h0;
    settle;
    $display("test read function done");
    xfer(8'h14, 1, 8'h04);
    sleep_mode <= 1'b1;
    for (int b = 2; b < 4; b++) begin
      ext <= 48'h1 << b;
      settle;
      ext <= 48'h0;
      seen = 0;
      repeat (8) begin
        @(posedge core_clk);
        seen += wake_req;
      end
      chk(seen, b == 2);
    end
    $display("test wake done");
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    complete_run;
  end
endmodule
bind io_sel_top io_sel_props #(.NPORT(NPORT)) u_props (.core_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .an_func_sel, .adc_chan, .sleep_mode, .an_path_en,
  .read_port_mode_flag, .wake_req);
